// ### rtl/adc_parallel_host_port.sv
// Parallel host port of a 12-bit sampling converter, seen from inside the converter.
// Assumes the host strobes and conversion clock pin are asynchronous to clk and that
// the analog front end returns a settled code on sample_code by the end of conversion.
// Operation
// - Completion output low when result ready
// - Read falling edge with select drives result
// - Internal mode write rise captures, starts acquisition
// - External mode second write rise starts conversion
// - Select high floats completion and data lines
// - Low eight lines bidirectional, upper output only
// - Top two bits choose power and clock
// - Bit five chooses acquisition timing source
// - Read falling edge releases completion output high
`timescale 1ns/100ps
module adc_parallel_host_port #(
  parameter int INT_DIV = adc_port_pkg::INT_DIV_DEF,
  parameter int ACQ_TICKS = adc_port_pkg::ACQ_TICKS_DEF,
  parameter int CONV_TICKS = adc_port_pkg::CONV_TICKS_DEF
) (
  // System clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Host strobes, all active low.
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  // Conversion clock pin.
  input wire logic conv_clk_pin,
  // Data bus: input half of the low eight lines, output and enables for all twelve.
  input wire logic [7:0] data_in,
  output logic [adc_port_pkg::DATA_W-1:0] data_out,
  output logic [adc_port_pkg::DATA_W-1:0] data_oe_n,
  // Completion pin, active low, with its own enable.
  output logic int_n,
  output logic int_oe_n,
  // Analog front end side.
  input wire logic [adc_port_pkg::DATA_W-1:0] sample_code,
  output logic acquiring,
  output logic converting,
  output adc_port_pkg::cfg_t active_cfg_ff
);

  // Synchronised pins: cs, rd, wr, conversion clock, then the data byte.
  logic [11:0] pins_s;
  logic [11:0] pins_d;
  logic cs_s;
  logic rd_s;
  logic rd_d;
  logic wr_s;
  logic wr_d;
  logic ck_s;
  logic ck_d;
  logic [7:0] data_d;

  // Edge events derived from synchronised pins.
  logic wr_rise;
  logic rd_fall;
  logic ck_fall;

  // Configuration, clock mode and sequencing state.
  adc_port_pkg::cfg_t cfg_ff;
  logic ext_clk_ff;
  adc_port_pkg::state_t state_ff;
  logic [$clog2(CONV_TICKS+ACQ_TICKS+1)-1:0] tick_cnt_ff;
  logic [$clog2(INT_DIV+1)-1:0] div_cnt_ff;
  logic div_tick;
  logic conv_tick;
  logic conv_end;

  // Result and completion flag.
  logic [adc_port_pkg::DATA_W-1:0] result_ff;
  logic done_ff;
  logic drive_ff;
  logic [adc_port_pkg::DATA_W-1:0] data_out_ff;
  logic int_oe_n_ff;

  // Strobes idle high; the data byte and clock pin idle low.
  pin_sync #(
    .W(12),
    .RST_VAL(12'h007)
  ) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .pin({data_in, conv_clk_pin, wr_n, rd_n, cs_n}),
    .sync_q(pins_s),
    .prev_q(pins_d)
  );

  assign cs_s = pins_s[0];
  assign rd_s = pins_s[1];
  assign rd_d = pins_d[1];
  assign wr_s = pins_s[2];
  assign wr_d = pins_d[2];
  assign ck_s = pins_s[3];
  assign ck_d = pins_d[3];
  // Byte is taken from the older stage, which lines up with the strobe still low,
  // because the host need not hold data once the strobe has risen.
  assign data_d = pins_d[11:4];

  // Strobes only count while the part is selected.
  assign wr_rise = wr_s & ~wr_d & ~cs_s;
  assign rd_fall = ~rd_s & rd_d & ~cs_s;
  assign ck_fall = ~ck_s & ck_d;

  // Free-running divider gives the internal conversion clock as an enable pulse.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt_ff <= '0;
    end else if (div_cnt_ff == ($clog2(INT_DIV+1))'(INT_DIV - 1)) begin
      div_cnt_ff <= '0;
    end else begin
      div_cnt_ff <= div_cnt_ff + 1'b1;
    end
  end

  assign div_tick = (div_cnt_ff == ($clog2(INT_DIV+1))'(INT_DIV - 1));
  // External mode counts falling edges of the host clock; in internal mode the pin is
  // expected static, and it is ignored anyway.
  assign conv_tick = ext_clk_ff ? ck_fall : div_tick;

  // Configuration byte register, loaded by any write while idle.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_ff <= adc_port_pkg::cfg_t'(adc_port_pkg::CFG_RST);
    end else if (wr_rise && state_ff == adc_port_pkg::ST_IDLE) begin
      cfg_ff <= adc_port_pkg::cfg_t'(data_d);
    end
  end

  // Clock mode only changes when a normal-operation code is written.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_clk_ff <= 1'b0;
    end else if (wr_rise && state_ff == adc_port_pkg::ST_IDLE &&
                 data_d[adc_port_pkg::PWR_HI_BIT]) begin
      ext_clk_ff <= data_d[adc_port_pkg::PWR_LO_BIT];
    end
  end

  // Conversion ends on the last tick of the conversion phase.
  assign conv_end = (state_ff == adc_port_pkg::ST_CONV) && conv_tick &&
    (tick_cnt_ff == ($bits(tick_cnt_ff))'(CONV_TICKS - 1));

  // Sequencer. Writes during acquisition or conversion are ignored, except the one
  // that ends an externally timed acquisition.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= adc_port_pkg::ST_IDLE;
      tick_cnt_ff <= '0;
    end else begin
      case (state_ff)
        adc_port_pkg::ST_IDLE: begin
          tick_cnt_ff <= '0;
          // Power-down codes store the byte but start nothing.
          if (wr_rise && data_d[adc_port_pkg::PWR_HI_BIT]) begin
            if (data_d[adc_port_pkg::ACQ_SEL_BIT]) begin
              state_ff <= adc_port_pkg::ST_EXT_ACQ;
            end else begin
              state_ff <= adc_port_pkg::ST_ACQ;
            end
          end
        end
        adc_port_pkg::ST_ACQ: begin
          // Acquisition length is fixed in conversion clock ticks.
          if (conv_tick) begin
            if (tick_cnt_ff == ($bits(tick_cnt_ff))'(ACQ_TICKS - 1)) begin
              tick_cnt_ff <= '0;
              state_ff <= adc_port_pkg::ST_CONV;
            end else begin
              tick_cnt_ff <= tick_cnt_ff + 1'b1;
            end
          end
        end
        adc_port_pkg::ST_EXT_ACQ: begin
          // The host times acquisition; its next write rise closes it.
          if (wr_rise) begin
            tick_cnt_ff <= '0;
            state_ff <= adc_port_pkg::ST_CONV;
          end
        end
        adc_port_pkg::ST_CONV: begin
          if (conv_end) begin
            tick_cnt_ff <= '0;
            state_ff <= adc_port_pkg::ST_IDLE;
          end else if (conv_tick) begin
            tick_cnt_ff <= tick_cnt_ff + 1'b1;
          end
        end
        default: begin
          state_ff <= adc_port_pkg::ST_IDLE;
          tick_cnt_ff <= '0;
        end
      endcase
    end
  end

  // Configuration handed to the front end is frozen when acquisition starts, so a
  // stray write cannot change the channel under a running conversion.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      active_cfg_ff <= adc_port_pkg::cfg_t'(adc_port_pkg::CFG_RST);
    end else if (wr_rise && state_ff == adc_port_pkg::ST_IDLE) begin
      active_cfg_ff <= adc_port_pkg::cfg_t'(data_d);
    end
  end

  assign acquiring = (state_ff == adc_port_pkg::ST_ACQ) ||
    (state_ff == adc_port_pkg::ST_EXT_ACQ);
  assign converting = (state_ff == adc_port_pkg::ST_CONV);

  // Result register holds the whole 12-bit code.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      result_ff <= '0;
    end else if (conv_end) begin
      result_ff <= sample_code;
    end
  end

  // Completion flag: set at conversion end, cleared by a read; set wins a tie.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      done_ff <= 1'b0;
    end else if (conv_end) begin
      done_ff <= 1'b1;
    end else if (rd_fall) begin
      done_ff <= 1'b0;
    end
  end

  // Read path: result latched and driven from the read edge until rd or cs rises.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      drive_ff <= 1'b0;
      data_out_ff <= '0;
    end else if (cs_s || rd_s) begin
      drive_ff <= 1'b0;
    end else if (rd_fall) begin
      drive_ff <= 1'b1;
      data_out_ff <= result_ff;
    end
  end

  // Completion pin floats whenever the part is deselected.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      int_oe_n_ff <= 1'b1;
    end else begin
      int_oe_n_ff <= cs_s;
    end
  end

  // All twelve lines share one enable; only the low eight have an input path.
  assign data_out = data_out_ff;
  assign data_oe_n = {adc_port_pkg::DATA_W{~drive_ff}};
  assign int_n = ~done_ff;
  assign int_oe_n = int_oe_n_ff;

  // Checks and coverage.
  chk_done_set: assert property (@(posedge clk) disable iff (!arst_n)
    conv_end |=> !int_n)
    else $error("completion not flagged after conversion end");
  chk_read_drive: assert property (@(posedge clk) disable iff (!arst_n)
    (rd_fall && !cs_s) ##1 (!cs_s && !rd_s) |-> !data_oe_n[0])
    else $error("result not driven after read edge");
  chk_cfg_capture: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_rise && state_ff == adc_port_pkg::ST_IDLE) |=> cfg_ff == $past(data_d))
    else $error("configuration byte not captured");
  chk_ext_end: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_rise && state_ff == adc_port_pkg::ST_EXT_ACQ) |=>
      state_ff == adc_port_pkg::ST_CONV)
    else $error("external acquisition not ended by write");
  chk_cs_float: assert property (@(posedge clk) disable iff (!arst_n)
    cs_s [*2] |-> int_oe_n && (&data_oe_n))
    else $error("outputs driven while deselected");
  // The enable is registered, so the select and strobe that allowed it are one edge old.
  chk_upper_out: assert property (@(posedge clk) disable iff (!arst_n)
    !data_oe_n[8] |-> $past(!rd_s && !cs_s) && $past(drive_ff || rd_fall))
    else $error("upper lines driven outside a read");
  chk_pd_idle: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_rise && state_ff == adc_port_pkg::ST_IDLE && !data_d[adc_port_pkg::PWR_HI_BIT])
      |=> state_ff == adc_port_pkg::ST_IDLE [*3])
    else $error("power-down write started a sequence");
  chk_acq_sel: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_rise && state_ff == adc_port_pkg::ST_IDLE && data_d[adc_port_pkg::PWR_HI_BIT])
      |=> state_ff == ($past(data_d[adc_port_pkg::ACQ_SEL_BIT]) ?
        adc_port_pkg::ST_EXT_ACQ : adc_port_pkg::ST_ACQ))
    else $error("wrong acquisition mode entered");
  chk_int_release: assert property (@(posedge clk) disable iff (!arst_n)
    (rd_fall && !conv_end) |=> int_n)
    else $error("completion not released by read");
  // Once a sequence runs, the applied configuration must not move until it ends.
  chk_cfg_apply: assert property (@(posedge clk) disable iff (!arst_n)
    ((acquiring || converting) && $past(acquiring || converting)) |-> $stable(active_cfg_ff))
    else $error("configuration changed under a running sequence");
  chk_result_full: assert property (@(posedge clk) disable iff (!arst_n)
    (rd_fall && !cs_s && !rd_s) |=> data_out == $past(result_ff))
    else $error("read result incomplete");
  cov_int_conv: cover property (@(posedge clk) disable iff (!arst_n)
    state_ff == adc_port_pkg::ST_ACQ ##[1:1000] conv_end);
  cov_ext_conv: cover property (@(posedge clk) disable iff (!arst_n)
    state_ff == adc_port_pkg::ST_EXT_ACQ ##[1:1000] conv_end);
  cov_read_done: cover property (@(posedge clk) disable iff (!arst_n)
    done_ff ##[1:1000] rd_fall);

endmodule

// ### rtl/adc_port_pkg.sv
// Shared constants and types for the converter's parallel host port.
// Assumes a single 40 MHz system clock; no other files are required.
package adc_port_pkg;

  // Widths of the host data bus and the configuration byte.
  localparam int DATA_W = 12;
  localparam int CFG_W = 8;

  // Field positions inside the configuration byte.
  localparam int PWR_HI_BIT = 7;
  localparam int PWR_LO_BIT = 6;
  localparam int ACQ_SEL_BIT = 5;
  localparam int IN_CFG_BIT = 4;
  localparam int POL_BIT = 3;
  localparam int CHAN_LSB = 0;

  // Configuration byte as held by the port; field order matches bit order 7 down to 0.
  typedef struct packed {
    logic power_mode_hi;
    logic power_mode_lo;
    logic acquire_timing_sel;
    logic input_config_sel;
    logic polarity_sel;
    logic [2:0] channel_sel;
  } cfg_t;

  // Reset value: full power-down, internal clock, internal acquisition, channel 0.
  localparam logic [CFG_W-1:0] CFG_RST = 8'h00;

  // System clock period and the longest read-strobe-to-completion-release delay.
  localparam int CLK_PERIOD_NS = 25;
  localparam int RD_INT_MAX_NS = 100;
  // Longest time rounds down; never below one cycle.
  localparam int RD_INT_CYC = (RD_INT_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 :
    (RD_INT_MAX_NS / CLK_PERIOD_NS);

  // Default sequencing counts, in conversion clock ticks or system cycles.
  localparam int INT_DIV_DEF = 8;
  localparam int ACQ_TICKS_DEF = 3;
  localparam int CONV_TICKS_DEF = 12;

  // Sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACQ,
    ST_EXT_ACQ,
    ST_CONV
  } state_t;

endpackage

// ### rtl/pin_sync.sv
// Two-flop synchroniser for a group of pins, with one extra stage for edge detection.
// Assumes the pins are asynchronous to clk; stage one feeds stage two only.
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Raw pins.
  input wire logic [W-1:0] pin,
  // Synchronised level and its value one cycle earlier.
  output logic [W-1:0] sync_q,
  output logic [W-1:0] prev_q
);

  // First stage may go metastable, so only the second stage reads it.
  logic [W-1:0] meta_ff;

  // Three stages in a chain; the third lets callers see edges safely.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= RST_VAL;
      sync_q <= RST_VAL;
      prev_q <= RST_VAL;
    end else begin
      meta_ff <= pin;
      sync_q <= meta_ff;
      prev_q <= sync_q;
    end
  end

endmodule

// ### bench/host_model.sv
// Host side model: drives the strobes, the low data lines and the conversion clock pin.
// Assumes the port's 40 MHz system clock; the bench calls its tasks one at a time.
`timescale 1ns/100ps
module host_model (
  // System clock, used only to pace the strobes.
  input wire logic clk,
  // Pins driven into the port.
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic [7:0] data_in,
  output logic conv_clk_pin
);
  logic ext_clk_on = 1'b0; // High while a free-running conversion clock is wanted.

  // All pins idle at time zero, deselected and with strobes high.
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    data_in = 8'h00;
    conv_clk_pin = 1'b0;
  end

  // A 4 MHz clock runs only when enabled; otherwise the pin is parked at one level.
  always begin
    wait (ext_clk_on);
    #125 conv_clk_pin = ~conv_clk_pin;
  end

  // Every pin change lands the same small delay after a rising edge.
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One configuration byte; data settles well before the rising strobe.
  task automatic write_cfg(input logic [7:0] b);
    step(1);
    data_in = b;
    wr_n = 1'b0;
    step(4);
    wr_n = 1'b1;
    step(3);
    data_in = ~b; // Released lines must not keep showing the last byte.
    step(3);
  endtask

  // One read access; the strobe is held long enough for the synchronisers.
  task automatic read_result();
    step(1);
    rd_n = 1'b0;
    step(6);
    rd_n = 1'b1;
    step(5);
  endtask

  // Chip select change, followed by time for the select path to settle.
  task automatic select(input logic v);
    step(1);
    cs_n = v;
    step(4);
  endtask
endmodule

// ### bench/tb_top.sv
// Self-checking bench for the converter's parallel host port.
// Assumes host_model drives the pins; the front end code is driven from here.
`timescale 1ns/100ps
`define CHK(g, e) check(12'(g), 12'(e))
module tb_top;
  logic clk = 1'b0; // System clock, 25 ns period.
  logic arst_n = 1'b0; // Reset, held low at the start.
  logic cs_n, rd_n, wr_n, conv_clk_pin;
  logic [7:0] data_in;
  logic [11:0] data_out, data_oe_n;
  logic [11:0] sample_code = 12'h000; // Front end code, held through each conversion.
  logic int_n, int_oe_n, acquiring, converting;
  adc_port_pkg::cfg_t cfg_q;
  logic [31:0] seed = 32'h90D9EAF8;
  logic [11:0] exp_q[$]; // Results expected on the bus, oldest first.
  logic oe_was_on = 1'b0;
  int fail_count = 0;
  int check_count = 0;

  always #12.5 clk = ~clk;

  host_model host (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .data_in(data_in),
    .conv_clk_pin(conv_clk_pin));

  // Default sequencing counts; a conversion then takes at most about 120 cycles on the internal clock, 150 on the external one.
  adc_parallel_host_port uut (
    .clk(clk), .arst_n(arst_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .conv_clk_pin(conv_clk_pin), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n), .int_n(int_n), .int_oe_n(int_oe_n), .sample_code(sample_code),
    .acquiring(acquiring), .converting(converting), .active_cfg_ff(cfg_q));

  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Waits a bounded time for the completion output to fall.
  task automatic wait_done();
    int n;
    n = 0;
    while (int_n !== 1'b0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    #1;
    `CHK(int_n, 1'b0);
  endtask

  // When the port starts driving, the oldest expected result is compared with the bus.
  always @(negedge clk) begin
    if (data_oe_n !== 12'h000 && data_oe_n !== 12'hFFF) begin
      `CHK(data_oe_n, 12'hFFF);
    end
    if (data_oe_n === 12'h000 && !oe_was_on) begin
      `CHK(exp_q.size() > 0, 1'b1);
      if (exp_q.size() > 0) begin
        `CHK(data_out, exp_q.pop_front());
      end
      `CHK(int_n, 1'b1);
    end
    oe_was_on = (data_oe_n === 12'h000);
  end

  // Main sequence.
  initial begin
    logic [7:0] b;
    repeat (5) @(posedge clk);
    #1;
    arst_n = 1'b1;
    `CHK(data_oe_n, 12'hFFF);
    `CHK(int_oe_n, 1'b1);
    `CHK(cfg_q, adc_port_pkg::CFG_RST);
    // Strobes while deselected must be ignored and leave the outputs floating.
    host.read_result();
    `CHK(data_oe_n, 12'hFFF);
    host.write_cfg(8'hA5);
    `CHK(cfg_q, 8'h00);
    host.select(1'b0);
    `CHK(int_oe_n, 1'b0);
    $display("test deselected done");
    // Every power and clock code, each with a random low field.
    for (int m = 0; m < 4; m++) begin
      host.ext_clk_on = (m == 3);
      b = {m[1:0], 1'b0, 5'(xorshift())};
      sample_code = 12'(xorshift());
      host.write_cfg(b);
      `CHK(cfg_q, b);
      if (m < 2) begin
        host.step(20);
        `CHK(acquiring | converting, 1'b0);
        `CHK(int_n, 1'b1);
      end else begin
        wait_done();
        exp_q.push_back(sample_code);
        host.read_result();
        `CHK(int_n, 1'b1);
      end
      $display("test mode %0d done", m);
    end
    // External acquisition waits for a second strobe, which does not replace the byte.
    b = {3'b111, 5'(xorshift())};
    sample_code = 12'(xorshift());
    host.write_cfg(b);
    host.step(30);
    `CHK({acquiring, converting, int_n}, 3'b101);
    host.write_cfg(~b);
    `CHK(cfg_q, b);
    `CHK(converting, 1'b1);
    wait_done();
    exp_q.push_back(sample_code);
    host.read_result();
    host.select(1'b1);
    `CHK(int_oe_n, 1'b1);
    `CHK(data_oe_n, 12'hFFF);
    $display("test external acquisition done");
    complete_run();
  end

  // Watchdog; the whole sequence needs well under ten thousand cycles.
  initial begin
    #1000000;
    fail_count++;
    complete_run();
  end
endmodule
